//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
  logic power_down = 0, return_done = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, pline = 0, m;
  logic [6:0] ireq = 0;
  logic [1:0] delay = 0;
  logic [7:0] sfr_rdata, taken_cnt;
  logic [15:0] vector_addr, taken_vec;
  logic [3:0] vector_src;
  logic wake, vector_ack, irq_pending, nest_high, nest_low;
  int miscompares = 0, num_checks = 0, cycles = 0;
  localparam logic [7:0] AD [6] = '{8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9,
    8'hF8};
  tlvi_ctrl uut (.clock, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .ext0_req(ireq[0]), .timer0_req(ireq[1]),
    .ext1_req(ireq[2]), .timer1_req(ireq[3]), .uart_req(ireq[4]),
    .twowire_req(ireq[5]), .timer2_req(ireq[6]),
    .port_interrupt_line(pline), .power_down, .wake, .vector_ack,
    .return_done, .irq_pending, .vector_addr, .vector_src, .nest_high,
    .nest_low);
  tlvi_core_model core (.clock, .rst, .irq_pending, .vector_addr, .delay,
    .vector_ack, .taken_vec, .taken_cnt);
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clock);
    sfr_wr = 0;
  endtask : wr
  task automatic rd(string n, logic [7:0] a, logic [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clock);
    sfr_rd = 0;
    chk(n, sfr_rdata, e);
  endtask : rd
  // Waits for the core model to take a vector, bounded
  task automatic serve(logic [15:0] e);
    logic [7:0] c0;
    c0 = taken_cnt;
    for (int k = 0; k < 40 && taken_cnt == c0; k++) @(negedge clock);
    chk("vector", taken_vec, e);
  endtask : serve
  task automatic ret();
    @(negedge clock);
    return_done = 1;
    @(negedge clock);
    return_done = 0;
  endtask : ret
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    rst = 0;
    foreach (AD[i]) rd("reset", AD[i], 8'h00);
    foreach (AD[i]) wr(AD[i], 8'h5A);
    foreach (AD[i]) rd("rw", AD[i], 8'h5A);
    wr(8'hB8, 8'hFF);
    rd("prio mask", 8'hB8, 8'h5F);
    foreach (AD[i]) wr(AD[i], 8'h00);
    rd("unmapped", 8'h99, 8'h00);
    $display("test registers done");
    wr(8'hA8, 8'h02);
    ireq = 7'h02;
    repeat (4) @(negedge clock);
    chk("gate", irq_pending, 1'b0);
    ireq = 0;
    for (int i = 0; i < 7; i++) begin
      delay = i[1:0];
      wr(8'hA8, 8'h80 | (8'h01 << i));
      ireq = 7'h01 << i;
      serve(16'h0003 + 16'(8 * i));
      ireq = 0;
      ret();
    end
    $display("test sources done");
    wr(8'hA8, 8'hFF);
    wr(8'hB8, 8'h08);
    ireq = 7'h1A;
    serve(16'h001B);
    chk("nest high", nest_high, 1'b1);
    ireq = 7'h12;
    repeat (3) @(negedge clock);
    chk("blocked", irq_pending, 1'b0);
    ret();
    serve(16'h000B);
    ireq = 7'h18;
    serve(16'h001B);
    chk("preempt", {nest_high, nest_low}, 2'b11);
    ireq = 7'h10;
    ret();
    chk("pop", {nest_high, nest_low}, 2'b01);
    ret();
    serve(16'h0023);
    ireq = 0;
    ret();
    wr(8'hB8, 8'h00);
    $display("test nesting done");
    wr(8'hA8, 8'h80);
    wr(8'hE9, 8'hAA);
    pline = 8'h55;
    power_down = 1;
    for (int j = 0; j < 8; j++) begin
      m = 8'h01 << j;
      wr(8'hE8, m);
      pline ^= m;
      @(negedge clock);
      pline ^= m;
      rd("glitch", 8'hC0, 8'h00);
      pline ^= m;
      serve(16'h003B + 16'(8 * j));
      chk("wake", wake, 1'b1);
      pline ^= m;
      repeat (3) @(negedge clock);
      rd("flag held", 8'hC0, m);
      wr(8'hC0, 8'h00);
      rd("flag clear", 8'hC0, 8'h00);
      chk("wake off", wake, 1'b0);
      ret();
    end
    $display("test port lines done");
    final_report();
  end
endmodule : tb_top

//--- tlvi_core_model.sv
`timescale 1ns/1ps
module tlvi_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controller offer
  input wire logic irq_pending,
  input wire logic [15:0] vector_addr,
  input wire logic [1:0] delay,
  // Fetch
  output logic vector_ack,
  output logic [15:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic [1:0] wait_cnt = 2'h0;
  initial vector_ack = 1'b0;
  initial taken_vec = 16'h0000;
  initial taken_cnt = 8'h00;
  always @(negedge clock) begin
    if (rst || !irq_pending || vector_ack) begin
      vector_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt >= delay) begin
      vector_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // Fetch is taken only on an edge that sees both
  always @(posedge clock) begin
    if (!rst && irq_pending === 1'b1 && vector_ack) begin
      taken_vec <= vector_addr;
      taken_cnt <= taken_cnt + 8'h01;
    end
  end
endmodule : tlvi_core_model

//--- tlvi_ctrl.sv
`timescale 1ns/1ps
`include "tlvi_defs.svh"
module tlvi_ctrl
  import tlvi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Special-function register access
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Internal peripheral requests and dedicated lines
  input wire logic ext0_req,
  input wire logic ext1_req,
  input wire logic timer0_req,
  input wire logic timer1_req,
  input wire logic timer2_req,
  input wire logic twowire_req,
  input wire logic uart_req,
  // Port 1 interrupt lines, external 9 down to 2
  input wire logic [7:0] port_interrupt_line,
  // Power-down state of the core
  input wire logic power_down,
  output logic wake,
  // Core side
  input wire logic vector_ack,
  input wire logic return_done,
  output logic irq_pending,
  output logic [15:0] vector_addr,
  output logic [3:0] vector_src,
  output logic nest_high,
  output logic nest_low
);
  tlvi_byte_t main_interrupt_enable;
  tlvi_byte_t main_interrupt_priority;
  tlvi_byte_t external_request_flags;
  tlvi_byte_t external_line_enable;
  tlvi_byte_t external_line_polarity;
  tlvi_byte_t external_line_priority;
  tlvi_byte_t next_mien;
  tlvi_byte_t next_mipr;
  tlvi_byte_t next_flags;
  tlvi_byte_t next_xen;
  tlvi_byte_t next_xpol;
  tlvi_byte_t next_xpri;
  tlvi_byte_t next_rdata;
  tlvi_byte_t port_seen;
  logic [14:0] req;
  logic [14:0] allow;
  logic [14:0] level;
  logic [14:0] cand_hi;
  logic [14:0] cand_lo;
  tlvi_src_t pick;
  logic pick_ok;
  tlvi_nest_t nest;
  tlvi_nest_t next_nest;
  logic low_saved;
  logic next_low_saved;
  logic next_irq;
  tlvi_vec_t next_vec;
  tlvi_src_t next_src;
  logic next_wake;
  logic next_nest_high;
  logic next_nest_low;

  // First set bit of a vector in service order
  function automatic tlvi_src_t first_of(input logic [14:0] v);
    tlvi_src_t r;
    r = `TLVI_SRC_X9;
    for (int i = `TLVI_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[3:0];
      end
    end
    return r;
  endfunction : first_of

  // Fixed vector of each source
  function automatic tlvi_vec_t vec_of(input tlvi_src_t s);
    tlvi_vec_t r;
    r = `TLVI_VEC_X0;
    unique case (s)
      `TLVI_SRC_X0: r = `TLVI_VEC_X0;
      `TLVI_SRC_S1: r = `TLVI_VEC_S1;
      `TLVI_SRC_X5: r = `TLVI_VEC_X5;
      `TLVI_SRC_T0: r = `TLVI_VEC_T0;
      `TLVI_SRC_T2: r = `TLVI_VEC_T2;
      `TLVI_SRC_X6: r = `TLVI_VEC_X6;
      `TLVI_SRC_X1: r = `TLVI_VEC_X1;
      `TLVI_SRC_X2: r = `TLVI_VEC_X2;
      `TLVI_SRC_X7: r = `TLVI_VEC_X7;
      `TLVI_SRC_T1: r = `TLVI_VEC_T1;
      `TLVI_SRC_X3: r = `TLVI_VEC_X3;
      `TLVI_SRC_X8: r = `TLVI_VEC_X8;
      `TLVI_SRC_S0: r = `TLVI_VEC_S0;
      `TLVI_SRC_X4: r = `TLVI_VEC_X4;
      `TLVI_SRC_X9: r = `TLVI_VEC_X9;
      default: r = `TLVI_VEC_X0;
    endcase
    return r;
  endfunction : vec_of

  // Gather main and second register bits into service order
  function automatic logic [14:0] to_order(input tlvi_byte_t main_bits,
    input tlvi_byte_t ext_bits);
    logic [14:0] r;
    r = '0;
    r[`TLVI_SRC_X0] = main_bits[`TLVI_BIT_X0];
    r[`TLVI_SRC_S1] = main_bits[`TLVI_BIT_S1];
    r[`TLVI_SRC_X5] = ext_bits[`TLVI_XBIT_X5];
    r[`TLVI_SRC_T0] = main_bits[`TLVI_BIT_T0];
    r[`TLVI_SRC_T2] = main_bits[`TLVI_BIT_T2];
    r[`TLVI_SRC_X6] = ext_bits[`TLVI_XBIT_X6];
    r[`TLVI_SRC_X1] = main_bits[`TLVI_BIT_X1];
    r[`TLVI_SRC_X2] = ext_bits[`TLVI_XBIT_X2];
    r[`TLVI_SRC_X7] = ext_bits[`TLVI_XBIT_X7];
    r[`TLVI_SRC_T1] = main_bits[`TLVI_BIT_T1];
    r[`TLVI_SRC_X3] = ext_bits[`TLVI_XBIT_X3];
    r[`TLVI_SRC_X8] = ext_bits[`TLVI_XBIT_X8];
    r[`TLVI_SRC_S0] = main_bits[`TLVI_BIT_S0];
    r[`TLVI_SRC_X4] = ext_bits[`TLVI_XBIT_X4];
    r[`TLVI_SRC_X9] = ext_bits[`TLVI_XBIT_X9];
    return r;
  endfunction : to_order

  tlvi_port_qual u_qual (
    .clock(clock),
    .rst(rst),
    .lines(port_interrupt_line),
    .polarity(external_line_polarity),
    .seen(port_seen)
  );

  // Register writes and flag capture
  always_comb begin
    next_mien = main_interrupt_enable;
    next_mipr = main_interrupt_priority;
    next_flags = external_request_flags;
    next_xen = external_line_enable;
    next_xpol = external_line_polarity;
    next_xpri = external_line_priority;
    if (sfr_wr) begin
      unique case (sfr_addr)
        `TLVI_ADDR_MIEN: next_mien = sfr_wdata;
        `TLVI_ADDR_MIPR: next_mipr = sfr_wdata & `TLVI_MIPR_MASK;
        `TLVI_ADDR_FLAG: next_flags = sfr_wdata;
        `TLVI_ADDR_XEN: next_xen = sfr_wdata;
        `TLVI_ADDR_XPOL: next_xpol = sfr_wdata;
        `TLVI_ADDR_XPRI: next_xpri = sfr_wdata;
        default: ;
      endcase
    end
    next_flags = next_flags | (port_seen & external_line_enable);
    next_rdata = `TLVI_RST_BYTE;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `TLVI_ADDR_MIEN: next_rdata = main_interrupt_enable;
        `TLVI_ADDR_MIPR: next_rdata = main_interrupt_priority;
        `TLVI_ADDR_FLAG: next_rdata = external_request_flags;
        `TLVI_ADDR_XEN: next_rdata = external_line_enable;
        `TLVI_ADDR_XPOL: next_rdata = external_line_polarity;
        `TLVI_ADDR_XPRI: next_rdata = external_line_priority;
        default: next_rdata = `TLVI_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      main_interrupt_enable <= `TLVI_RST_BYTE;
      main_interrupt_priority <= `TLVI_RST_BYTE;
      external_request_flags <= `TLVI_RST_BYTE;
      external_line_enable <= `TLVI_RST_BYTE;
      external_line_polarity <= `TLVI_RST_BYTE;
      external_line_priority <= `TLVI_RST_BYTE;
      sfr_rdata <= `TLVI_RST_BYTE;
    end else begin
      main_interrupt_enable <= next_mien;
      main_interrupt_priority <= next_mipr;
      external_request_flags <= next_flags;
      external_line_enable <= next_xen;
      external_line_polarity <= next_xpol;
      external_line_priority <= next_xpri;
      sfr_rdata <= next_rdata;
    end
  end

  // Source vectors in service order
  always_comb begin
    req = to_order({1'b0, timer2_req, twowire_req, uart_req, timer1_req,
      ext1_req, timer0_req, ext0_req}, external_request_flags);
    allow = to_order(main_interrupt_enable, external_line_enable);
    level = to_order(main_interrupt_priority, external_line_priority);
    // Two-wire has no level bit of its own, so it always sits low
    level[`TLVI_SRC_S1] = 1'b0;
  end

  // Arbitration
  always_comb begin
    cand_hi = req & allow & level &
      {`TLVI_NSRC{main_interrupt_enable[`TLVI_BIT_GATE]}};
    cand_lo = req & allow & ~level &
      {`TLVI_NSRC{main_interrupt_enable[`TLVI_BIT_GATE]}};
    if (nest == TLVI_HIGH) begin
      cand_hi = '0;
      cand_lo = '0;
    end else if (nest == TLVI_LOW) begin
      cand_lo = '0;
    end
    // high before low, fixed order within level
    pick_ok = |cand_hi || |cand_lo;
    pick = (|cand_hi) ? first_of(cand_hi) : first_of(cand_lo);
  end

  // Nesting state
  always_comb begin
    next_nest = nest;
    next_low_saved = low_saved;
    next_irq = pick_ok && !vector_ack;
    next_vec = vec_of(pick);
    next_src = pick;
    next_wake = power_down && main_interrupt_enable[`TLVI_BIT_GATE] &&
      |(port_seen & external_line_enable);
    if (vector_ack && irq_pending) begin
      if (level[vector_src]) begin
        next_nest = TLVI_HIGH;
        next_low_saved = (nest == TLVI_LOW);
      end else begin
        next_nest = TLVI_LOW;
      end
    end else if (return_done) begin
      unique case (nest)
        TLVI_IDLE: next_nest = TLVI_IDLE;
        TLVI_LOW: next_nest = TLVI_IDLE;
        TLVI_HIGH: next_nest = low_saved ? TLVI_LOW : TLVI_IDLE;
      endcase
      if (nest == TLVI_HIGH) begin
        next_low_saved = 1'b0;
      end
    end
    next_nest_high = (next_nest == TLVI_HIGH);
    // A preempted low routine still counts as active
    next_nest_low = (next_nest == TLVI_LOW) || next_low_saved;
  end

  // request registered, served a cycle after recognition
  always_ff @(posedge clock) begin
    if (rst) begin
      nest <= TLVI_IDLE;
      low_saved <= 1'b0;
      irq_pending <= 1'b0;
      vector_addr <= `TLVI_VEC_X0;
      vector_src <= `TLVI_SRC_X0;
      nest_high <= 1'b0;
      nest_low <= 1'b0;
      wake <= 1'b0;
    end else begin
      nest <= next_nest;
      low_saved <= next_low_saved;
      irq_pending <= next_irq;
      vector_addr <= next_vec;
      vector_src <= next_src;
      nest_high <= next_nest_high;
      nest_low <= next_nest_low;
      wake <= next_wake;
    end
  end
endmodule : tlvi_ctrl

//--- tlvi_defs.svh
`ifndef TLVI_DEFS_SVH
`define TLVI_DEFS_SVH

// Special-function addresses
`define TLVI_ADDR_MIEN 8'hA8
`define TLVI_ADDR_MIPR 8'hB8
`define TLVI_ADDR_FLAG 8'hC0
`define TLVI_ADDR_XEN 8'hE8
`define TLVI_ADDR_XPOL 8'hE9
`define TLVI_ADDR_XPRI 8'hF8

// Reset value and priority register write mask
`define TLVI_RST_BYTE 8'h00
`define TLVI_MIPR_MASK 8'h5F

// Field positions in the main enable and priority registers
`define TLVI_BIT_GATE 7
`define TLVI_BIT_T2 6
`define TLVI_BIT_S1 5
`define TLVI_BIT_S0 4
`define TLVI_BIT_T1 3
`define TLVI_BIT_X1 2
`define TLVI_BIT_T0 1
`define TLVI_BIT_X0 0

// Field positions of external 2 to 9 in the second registers
`define TLVI_XBIT_X2 0
`define TLVI_XBIT_X3 1
`define TLVI_XBIT_X4 2
`define TLVI_XBIT_X5 3
`define TLVI_XBIT_X6 4
`define TLVI_XBIT_X7 5
`define TLVI_XBIT_X8 6
`define TLVI_XBIT_X9 7

// Source indices, in fixed service order (0 is first)
`define TLVI_NSRC 15
`define TLVI_SRC_X0 4'h0
`define TLVI_SRC_S1 4'h1
`define TLVI_SRC_X5 4'h2
`define TLVI_SRC_T0 4'h3
`define TLVI_SRC_T2 4'h4
`define TLVI_SRC_X6 4'h5
`define TLVI_SRC_X1 4'h6
`define TLVI_SRC_X2 4'h7
`define TLVI_SRC_X7 4'h8
`define TLVI_SRC_T1 4'h9
`define TLVI_SRC_X3 4'hA
`define TLVI_SRC_X8 4'hB
`define TLVI_SRC_S0 4'hC
`define TLVI_SRC_X4 4'hD
`define TLVI_SRC_X9 4'hE

// Vector addresses
`define TLVI_VEC_X0 16'h0003
`define TLVI_VEC_T0 16'h000B
`define TLVI_VEC_X1 16'h0013
`define TLVI_VEC_T1 16'h001B
`define TLVI_VEC_S0 16'h0023
`define TLVI_VEC_S1 16'h002B
`define TLVI_VEC_T2 16'h0033
`define TLVI_VEC_X2 16'h003B
`define TLVI_VEC_X3 16'h0043
`define TLVI_VEC_X4 16'h004B
`define TLVI_VEC_X5 16'h0053
`define TLVI_VEC_X6 16'h005B
`define TLVI_VEC_X7 16'h0063
`define TLVI_VEC_X8 16'h006B
`define TLVI_VEC_X9 16'h0073

`endif

//--- tlvi_pkg.sv
package tlvi_pkg;
  typedef logic [7:0] tlvi_byte_t;
  typedef logic [3:0] tlvi_src_t;
  typedef logic [15:0] tlvi_vec_t;
  typedef enum logic [2:0] {
    TLVI_IDLE = 3'b001,
    TLVI_LOW = 3'b010,
    TLVI_HIGH = 3'b100
  } tlvi_nest_t;
endpackage : tlvi_pkg

//--- tlvi_port_qual.sv
`timescale 1ns/1ps
`include "tlvi_defs.svh"
module tlvi_port_qual
  import tlvi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Port lines and polarity
  input wire logic [7:0] lines,
  input wire logic [7:0] polarity,
  // Qualified active levels
  output logic [7:0] seen
);
  tlvi_byte_t active;
  tlvi_byte_t held;
  tlvi_byte_t next_held;
  tlvi_byte_t next_seen;

  always_comb begin
    active = ~(lines ^ polarity);
    next_held = active;
    next_seen = active & held;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      held <= `TLVI_RST_BYTE;
      seen <= `TLVI_RST_BYTE;
    end else begin
      held <= next_held;
      seen <= next_seen;
    end
  end
endmodule : tlvi_port_qual

//--- tlvi_props.sv
`timescale 1ns/1ps
module tlvi_props
  import tlvi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register access
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  // Power-down
  input wire logic power_down,
  input wire logic wake,
  // Core side
  input wire logic vector_ack,
  input wire logic return_done,
  input wire logic irq_pending,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] vector_src,
  input wire logic nest_high,
  input wire logic nest_low
);
  localparam logic [7:0] VT [15] = '{8'h03, 8'h2B, 8'h53, 8'h0B, 8'h33,
    8'h5B, 8'h13, 8'h3B, 8'h63, 8'h1B, 8'h43, 8'h6B, 8'h23, 8'h4B, 8'h73};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without read");
  a_prio_unused: assert property (sfr_rd && sfr_addr == 8'hB8 |=>
    sfr_rdata[7] == 1'b0 && sfr_rdata[5] == 1'b0)
    else $error("unused priority bits read nonzero");
  a_vec_map: assert property (irq_pending |->
    vector_src <= 4'hE && vector_addr == {8'h00, VT[vector_src]})
    else $error("vector address does not match source");
  a_ack_drop: assert property (irq_pending && vector_ack |=>
    !irq_pending)
    else $error("offer stays after ack");
  a_ack_nest: assert property (irq_pending && vector_ack |=>
    nest_high || nest_low)
    else $error("no nest level after ack");
  a_high_quiet: assert property (nest_high |-> !irq_pending)
    else $error("offer during high routine");
  a_ret_pop: assert property (return_done && nest_high && !nest_low &&
    !vector_ack |=> !nest_high && !nest_low)
    else $error("return did not pop high level");
  a_wake_cause: assert property (wake |-> $past(power_down))
    else $error("wake outside power-down");
endmodule : tlvi_props
bind tlvi_ctrl tlvi_props u_props (.clock(clock), .rst(rst),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata),
  .power_down(power_down), .wake(wake), .vector_ack(vector_ack),
  .return_done(return_done), .irq_pending(irq_pending),
  .vector_addr(vector_addr), .vector_src(vector_src),
  .nest_high(nest_high), .nest_low(nest_low));
